// >>> src/fre_pkg.sv
/*
  shared constants, types and phase decoding for the multi-I/O fast read engine.
  assumes both link ends import it; no clock or reset of its own.
*/
package fre_pkg;
  // command codes
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO  = 8'heb;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  // phase sizes
  localparam int         ADDR_BITS   = 24;
  localparam int         CMD_BITS    = 8;
  localparam logic [3:0] DUMMY_OUT   = 4'h8;
  localparam logic [3:0] DUMMY_QIO   = 4'h4;
  // read mode and wrap fields
  localparam int         CONT_LSB     = 4;
  localparam logic [1:0] CONT_SEL     = 2'h2;
  localparam int         WRAP_DIS_POS = 4;
  localparam int         WRAP_LEN_LSB = 5;
  localparam int         WLEN_W       = 2;
  localparam logic       WRAP_DIS_RST = 1'b1;
  localparam int         WRAP_MIN     = 8;
  // host register map, byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_MODE  = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int         CTRL_SKIP = 8;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  // link clock: half period in system clocks
  localparam int         SCLK_HALF_DEF = 4;

  // lane width as a shift amount: 0 one lane, 1 two, 2 four
  typedef enum logic [1:0] {W1 = 2'h0, W2 = 2'h1, W4 = 2'h2} fre_wid_t;

  typedef struct packed {
    logic     ok;    // known command
    logic     qe;    // needs quad enable
    logic     wuse;  // read obeys wrap setting
    logic     wset;  // mode byte loads wrap setting
    fre_wid_t aw;    // address and mode width
    logic     md;    // mode byte present
    logic [3:0] dum; // dummy clocks
    fre_wid_t dw;    // data width
  } fre_plan_t;

  // lanes per clock for a width code
  function automatic logic [2:0] fre_lanes(input fre_wid_t w);
    fre_lanes = 3'(1 << w);
  endfunction : fre_lanes

  // phase plan of each command
  function automatic fre_plan_t fre_plan(input logic [7:0] op);
    fre_plan_t p;
    p = '0;
    case (op)
      OP_DUAL_OUT: begin
        p.ok = 1'b1; p.aw = W1; p.dum = DUMMY_OUT; p.dw = W2;
      end
      OP_QUAD_OUT: begin
        p.ok = 1'b1; p.qe = 1'b1; p.aw = W1; p.dum = DUMMY_OUT; p.dw = W4;
      end
      OP_DUAL_IO: begin
        p.ok = 1'b1; p.aw = W2; p.md = 1'b1; p.dw = W2;
      end
      OP_QUAD_IO: begin
        p.ok = 1'b1; p.qe = 1'b1; p.wuse = 1'b1; p.aw = W4; p.md = 1'b1;
        p.dum = DUMMY_QIO; p.dw = W4;
      end
      OP_SET_WRAP: begin
        p.ok = 1'b1; p.wset = 1'b1; p.aw = W4; p.md = 1'b1;
      end
      default: p = '0;
    endcase
    fre_plan = p;
  endfunction : fre_plan
endpackage : fre_pkg

// >>> src/fre_link_if.sv
/*
  serial link between the fast read host and the flash end.
  assumes io lines have a weak pull-up: an undriven line reads high.
*/
`timescale 1ns/10ps
interface fre_link_if;
  logic       cs_b;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // wire level: flash end, else host, else pull-up
  assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

  modport dev  (input cs_b, sclk, io, output d_io_o, d_io_oe);
  modport host (output cs_b, sclk, h_io_o, h_io_oe, input io);
endinterface : fre_link_if

// >>> src/fre_flash_dev.sv
/*
  flash end of the link: fast read dual/quad output, dual/quad I/O with
  continuous read, and burst wrap setting, over a byte array.
  assumes link pins are asynchronous to clock and sclk runs far below clock.
*/
// Decided for this implementation: the placing of the registers and the APB register port.
// What this block does
// R1 - dual output read drives two lines
// R2 - eight dummy clocks after output-read address
// R3 - dummy clock inputs are ignored
// R4 - host releases io0 before data
// R5 - quad output needs quad enable, four lanes
// R6 - dual I/O address two bits per clock
// R7 - mode byte follows address, low nibble ignored
// R8 - dual I/O mode 10 skips next opcode
// R9 - quad I/O mode 10 skips next opcode
// R10 - other mode value restores opcode decoding
// R11 - host exits dual continuous with ones
// R12 - host exits quad continuous with ones
// R13 - quad I/O four lanes, four dummies
// R14 - quad I/O refused without quad enable
// R15 - wrap inside aligned section until deselect
// R16 - wrap command: opcode, 24 dummy, 8 bits
// R17 - bit4 disables wrap, bits 6-5 length
// R18 - wrap setting kept for later reads
// R19 - reset leaves wrap disabled
// R20 - sample rising, shift falling, MSB first
// R21 - address increments per byte otherwise
// R22 - release lines when deselected, used lanes
`timescale 1ns/10ps
module fre_flash_dev #(
  parameter int MEM_AW = 8
) (
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  fre_link_if.dev                           link,
  input  wire logic                         quad_io_enable_bit,
  input  wire logic                         soft_rst,
  input  wire logic                         mem_we,
  input  wire logic [MEM_AW-1:0]            mem_addr,
  input  wire logic [7:0]                   mem_wdata,
  output logic                              cont_active,
  output logic                              wrap_disable_bit,
  output logic [fre_pkg::WLEN_W-1:0]        wrap_length_field
);
  import fre_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CMD = 3'h1, ST_ADDR = 3'h3, ST_MODE = 3'h2,
    ST_DUM = 3'h6, ST_DATA = 3'h7, ST_SKIP = 3'h5
  } fre_dst_t;

  generate
    if (MEM_AW < 8 || MEM_AW > ADDR_BITS) begin : g_bad_aw
      $error("MEM_AW must lie in 8..24");
    end
  endgenerate

  logic [7:0]        mem [1 << MEM_AW];
  logic [2:0]        cs_s;
  logic [2:0]        ck_s;
  logic [3:0]        io_s1;
  logic [3:0]        io_s2;
  fre_dst_t          st_r;
  fre_plan_t         pl_r;
  fre_plan_t         cmd_pl;
  logic [5:0]        cnt_r;
  logic [5:0]        plen;
  logic [7:0]        op_r;
  logic [7:0]        mb_r;
  logic [7:0]        mb_nxt;
  logic [23:0]       addr_r;
  logic [23:0]       addr_nxt;
  logic [23:0]       wmask;
  logic              cont_r;
  logic              wrap_dis_r;
  logic [WLEN_W-1:0] wrap_len_r;
  logic [7:0]        sh_r;
  logic [7:0]        byte_cur;
  logic [2:0]        bit_r;
  logic [3:0]        io_o_r;
  logic [3:0]        io_oe_r;
  fre_wid_t          cw;
  logic              sel;
  logic              start;
  logic              rise;
  logic              fall;
  logic              last;
  logic              wrap_on;
  logic              wrap_ld;

  // shift lanes into a byte, MSB first
  function automatic logic [7:0] sh8(input logic [7:0] o, input logic [3:0] b, input fre_wid_t w);
    case (w)
      W2:      sh8 = {o[5:0], b[1:0]};
      W4:      sh8 = {o[3:0], b};
      default: sh8 = {o[6:0], b[0]};
    endcase
  endfunction : sh8

  // shift lanes into the address, MSB first
  function automatic logic [23:0] sh24(input logic [23:0] o, input logic [3:0] b, input fre_wid_t w);
    case (w)
      W2:      sh24 = {o[21:0], b[1:0]};
      W4:      sh24 = {o[19:0], b};
      default: sh24 = {o[22:0], b[0]};
    endcase
  endfunction : sh24

  // two-flop synchronisers, third stage for edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cs_s  <= 3'h7;
      ck_s  <= 3'h0;
      io_s1 <= 4'hf;
      io_s2 <= 4'hf;
    end else begin
      cs_s  <= {cs_s[1:0], link.cs_b};
      ck_s  <= {ck_s[1:0], link.sclk};
      io_s1 <= link.io;
      io_s2 <= io_s1;
    end
  end

  // link events
  assign sel   = ~cs_s[1];
  assign start = ~cs_s[1] & cs_s[2];
  assign rise  = ck_s[1] & ~ck_s[2];  // [R20]
  assign fall  = ~ck_s[1] & ck_s[2];  // [R20]

  // width and length of the current input phase
  always_comb begin
    cw   = (st_r == ST_CMD) ? W1 : pl_r.aw;
    plen = 6'(CMD_BITS);
    case (st_r)
      ST_ADDR: plen = 6'(ADDR_BITS >> pl_r.aw);  // [R6] [R13]
      ST_MODE: plen = 6'(CMD_BITS >> pl_r.aw);   // [R7]
      ST_DUM:  plen = {2'h0, pl_r.dum};          // [R2] [R13]
      default: plen = 6'(CMD_BITS);
    endcase
  end

  assign last    = (cnt_r == plen - 6'h1);
  assign mb_nxt  = sh8(mb_r, io_s2, cw);
  assign cmd_pl  = fre_plan(mb_nxt);
  assign wrap_ld = sel & ~start & rise & (st_r == ST_MODE) & last & pl_r.wset;

  // command sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r   <= ST_IDLE;
      cnt_r  <= 6'h0;
      pl_r   <= '0;
      op_r   <= 8'h00;
      mb_r   <= 8'h00;
      addr_r <= 24'h00_0000;
      cont_r <= 1'b0;
    end else if (soft_rst) begin
      st_r   <= ST_IDLE;
      cont_r <= 1'b0;
    end else if (!sel) begin
      st_r <= ST_IDLE;  // [R22]
    end else if (start) begin
      cnt_r <= 6'h0;
      mb_r  <= 8'h00;
      if (cont_r) begin
        pl_r <= fre_plan(op_r);  // [R8] [R9]
        st_r <= ST_ADDR;
      end else begin
        st_r <= ST_CMD;  // [R10]
      end
    end else if (rise) begin
      cnt_r <= cnt_r + 6'h1;
      case (st_r)
        ST_CMD: begin
          mb_r <= mb_nxt;
          if (last) begin
            cnt_r <= 6'h0;
            op_r  <= mb_nxt;
            pl_r  <= cmd_pl;
            if (!cmd_pl.ok || (cmd_pl.qe && !quad_io_enable_bit)) begin
              st_r <= ST_SKIP;  // [R5] [R14]
            end else begin
              st_r <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          addr_r <= sh24(addr_r, io_s2, cw);  // [R6]
          if (last) begin
            cnt_r <= 6'h0;
            st_r  <= pl_r.md ? ST_MODE : ST_DUM;  // [R2]
          end
        end
        ST_MODE: begin
          mb_r <= mb_nxt;
          if (last) begin
            cnt_r <= 6'h0;
            if (pl_r.wset) begin
              st_r <= ST_SKIP;  // [R16]
            end else begin
              cont_r <= (mb_nxt[CONT_LSB +: 2] == CONT_SEL);  // [R7] [R8] [R9] [R10]
              st_r   <= (pl_r.dum != 4'h0) ? ST_DUM : ST_DATA;
            end
          end
        end
        ST_DUM: begin
          if (last) begin  // inputs not looked at here [R3]
            cnt_r <= 6'h0;
            st_r  <= ST_DATA;
          end
        end
        default: ;
      endcase
    end else if (fall && st_r == ST_DATA && bit_r == 3'h0) begin
      addr_r <= addr_nxt;  // [R21]
    end
  end

  // wrap setting, disabled after any reset
  always_ff @(posedge clock) begin
    if (!rst_b || soft_rst) begin
      wrap_dis_r <= WRAP_DIS_RST;  // [R19]
      wrap_len_r <= '0;
    end else if (wrap_ld) begin
      wrap_dis_r <= mb_nxt[WRAP_DIS_POS];              // [R16] [R17] [R18]
      wrap_len_r <= mb_nxt[WRAP_LEN_LSB +: WLEN_W];    // [R17]
    end
  end

  // next read address, confined to the section when wrapping
  assign wrap_on  = pl_r.wuse & ~wrap_dis_r;
  assign wmask    = 24'((WRAP_MIN << wrap_len_r) - 1);
  assign addr_nxt = wrap_on ? ((addr_r & ~wmask) | ((addr_r + 24'h1) & wmask))  // [R15]
                            : addr_r + 24'h1;                                   // [R21]
  assign byte_cur = (bit_r == 3'h0) ? mem[addr_r[MEM_AW-1:0]] : sh_r;

  // data shifter on falling edges
  always_ff @(posedge clock) begin
    if (!rst_b || !sel || st_r != ST_DATA) begin
      io_o_r  <= 4'h0;
      io_oe_r <= 4'h0;  // [R22]
      bit_r   <= 3'h0;
      sh_r    <= 8'h00;
    end else if (fall) begin
      sh_r  <= byte_cur << fre_lanes(pl_r.dw);
      bit_r <= bit_r + fre_lanes(pl_r.dw);
      case (pl_r.dw)
        W2: begin
          io_o_r  <= {2'h0, byte_cur[7:6]};  // [R1] [R20]
          io_oe_r <= 4'h3;                   // [R1] [R22]
        end
        W4: begin
          io_o_r  <= byte_cur[7:4];  // [R5] [R13]
          io_oe_r <= 4'hf;
        end
        default: begin
          io_o_r  <= {2'h0, byte_cur[7], 1'b0};
          io_oe_r <= 4'h2;
        end
      endcase
    end
  end

  // preload port
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  assign link.d_io_o       = io_o_r;
  assign link.d_io_oe      = io_oe_r;
  assign cont_active       = cont_r;
  assign wrap_disable_bit  = wrap_dis_r;
  assign wrap_length_field = wrap_len_r;
endmodule : fre_flash_dev

// >>> src/fre_spi_host.sv
/*
  host end of the link: runs one read or wrap command per software order,
  makes sclk by dividing clock, and keeps the last four bytes read.
  assumes an APB master on the register side.
*/
`timescale 1ns/10ps
module fre_spi_host #(
  parameter int SCLK_HALF = fre_pkg::SCLK_HALF_DEF
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  fre_link_if.host                   link
);
  import fre_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_CMD = 3'h1, H_ADDR = 3'h3, H_MODE = 3'h2,
    H_DUM = 3'h6, H_DATA = 3'h7, H_END = 3'h5
  } fre_hst_t;

  generate
    if (SCLK_HALF < 4) begin : g_bad_half
      $error("SCLK_HALF below 4 outruns the pin synchronisers");
    end
  endgenerate

  fre_hst_t   hs_r;
  fre_hst_t   nph;
  fre_plan_t  pl;
  fre_wid_t   cw;
  logic [7:0] op_r;
  logic       skip_r;
  logic [23:0] addr_r;
  logic [7:0] mode_r;
  logic [15:0] count_r;
  logic [31:0] rdata_r;
  logic [31:0] prdata_r;
  logic [39:0] tx_r;
  logic [15:0] left_r;
  logic [15:0] nlen;
  logic [15:0] half_r;
  logic       sclk_r;
  logic       cs_b_r;
  logic       go_r;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic       run;
  logic       tick;
  logic       fe;
  logic       wr;

  assign pl   = fre_plan(op_r);
  assign wr   = psel & penable & pwrite;
  assign run  = (hs_r != H_IDLE) && (hs_r != H_END);
  assign tick = run && (half_r == 16'(SCLK_HALF - 1));
  assign fe   = tick & sclk_r;

  // software registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      op_r    <= 8'h00;
      skip_r  <= 1'b0;
      addr_r  <= 24'h00_0000;
      mode_r  <= 8'hff;
      count_r <= COUNT_RST;
      go_r    <= 1'b0;
    end else begin
      go_r <= wr && paddr == REG_CTRL && hs_r == H_IDLE && !go_r;
      if (wr && paddr == REG_CTRL && hs_r == H_IDLE && !go_r) begin
        op_r   <= pwdata[7:0];
        skip_r <= pwdata[CTRL_SKIP];
      end
      if (wr && paddr == REG_ADDR)  addr_r  <= pwdata[23:0];
      if (wr && paddr == REG_MODE)  mode_r  <= pwdata[7:0];
      if (wr && paddr == REG_COUNT) count_r <= pwdata[15:0];
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        REG_CTRL:  prdata_r <= {23'h0, skip_r, op_r};
        REG_ADDR:  prdata_r <= {8'h00, addr_r};
        REG_MODE:  prdata_r <= {24'h00_0000, mode_r};
        REG_COUNT: prdata_r <= {16'h0000, count_r};
        REG_STAT:  prdata_r <= {31'h0, (hs_r != H_IDLE) | go_r};
        REG_RDATA: prdata_r <= rdata_r;
        default:   prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // return lines through two flops
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      io_s1 <= 4'hf;
      io_s2 <= 4'hf;
    end else begin
      io_s1 <= link.io;
      io_s2 <= io_s1;
    end
  end

  // sclk divider, idles low
  always_ff @(posedge clock) begin
    if (!rst_b || !run) begin
      half_r <= 16'h0;
      sclk_r <= 1'b0;
    end else if (tick) begin
      half_r <= 16'h0;
      sclk_r <= ~sclk_r;
    end else begin
      half_r <= half_r + 16'h1;
    end
  end

  // phase order and lane width
  always_comb begin
    cw = (hs_r == H_CMD) ? W1 : (hs_r == H_DATA) ? pl.dw : pl.aw;
    case (hs_r)
      H_CMD:   nph = H_ADDR;
      H_ADDR:  nph = pl.md ? H_MODE : H_DUM;                        // [R2]
      H_MODE:  nph = (pl.dum != 4'h0) ? H_DUM : pl.wset ? H_END : H_DATA;  // [R7] [R16]
      H_DUM:   nph = H_DATA;
      default: nph = H_END;
    endcase
    case (nph)
      H_ADDR:  nlen = 16'(ADDR_BITS >> pl.aw) - 16'h1;             // [R6] [R13]
      H_MODE:  nlen = 16'(CMD_BITS >> pl.aw) - 16'h1;
      H_DUM:   nlen = {12'h0, pl.dum} - 16'h1;                     // [R2] [R13]
      H_DATA:  nlen = 16'((32'(count_r) * 8) >> pl.dw) - 16'h1;
      default: nlen = 16'h0;
    endcase
  end

  // transfer engine: outputs change on falling sclk
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hs_r    <= H_IDLE;
      cs_b_r  <= 1'b1;
      tx_r    <= 40'h00_0000_0000;
      left_r  <= 16'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      case (hs_r)
        H_IDLE: begin
          if (go_r) begin
            cs_b_r <= 1'b0;
            if (skip_r) begin
              tx_r   <= {addr_r, mode_r, 8'h00};  // no opcode in continuous mode
              hs_r   <= H_ADDR;
              left_r <= 16'(ADDR_BITS >> pl.aw) - 16'h1;
            end else begin
              tx_r   <= {op_r, addr_r, mode_r};
              hs_r   <= H_CMD;
              left_r <= 16'(CMD_BITS - 1);
            end
          end
        end
        H_END: begin
          cs_b_r <= 1'b1;
          hs_r   <= H_IDLE;
        end
        default: begin
          if (fe) begin
            tx_r <= tx_r << fre_lanes(cw);
            if (hs_r == H_DATA) begin
              case (cw)
                W2:      rdata_r <= {rdata_r[29:0], io_s2[1:0]};
                W4:      rdata_r <= {rdata_r[27:0], io_s2};
                default: rdata_r <= {rdata_r[30:0], io_s2[1]};
              endcase
            end
            if (left_r == 16'h0) begin
              hs_r   <= nph;
              left_r <= nlen;
            end else begin
              left_r <= left_r - 16'h1;
            end
          end
        end
      endcase
    end
  end

  // pin drive: released from the dummy phase on
  assign link.cs_b    = cs_b_r;
  assign link.sclk    = sclk_r;
  assign link.h_io_o  = (cw == W4) ? tx_r[39:36] : (cw == W2) ? {2'h0, tx_r[39:38]} : {3'h0, tx_r[39]};
  assign link.h_io_oe = (hs_r == H_CMD) ? 4'h1 :                                    // [R11] [R12]
                        (hs_r == H_ADDR || hs_r == H_MODE) ? 4'(fre_lanes(cw) * 4'h1 == 4'h1 ? 4'h1 :
                        (cw == W2) ? 4'h3 : 4'hf) : 4'h0;                            // [R4]
endmodule : fre_spi_host

// >>> tb/fre_asserts.sv
/*
  link checker: framing, lane use and clocking seen on the joined link.
  assumes instantiation beside the link interface, on the bench clock and reset.
*/
`timescale 1ns/10ps
module fre_asserts (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       sclk,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // flash lets go of the lines after deselect
  property p_rel; $rose(cs_b) |-> ##6 (d_io_oe == 4'h0); endproperty
  a_rel: assert property (p_rel) else $error("flash still drives after deselect");
  // flash drives no lane, two lanes or four lanes only
  property p_lanes; d_io_oe inside {4'h0, 4'h3, 4'hf}; endproperty
  a_lanes: assert property (p_lanes) else $error("odd flash lane set");
  // never both ends on one line
  property p_nofight; (d_io_oe & h_io_oe) == 4'h0; endproperty
  a_nofight: assert property (p_nofight) else $error("both ends drive a line");
  // link clock rests low outside a frame
  property p_idle; cs_b |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("sclk high while deselected");
  // host data steady over the high half
  property p_hhold; sclk && $past(sclk) |-> $stable(h_io_o & h_io_oe); endproperty
  a_hhold: assert property (p_hhold) else $error("host data moved while sclk high");
  // flash data steady over the high half
  property p_dhold; sclk && $past(sclk) |-> $stable(d_io_o & d_io_oe); endproperty
  a_dhold: assert property (p_dhold) else $error("flash data moved while sclk high");
  // high half lasts four system clocks
  property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("sclk high half not four clocks");
  // a frame opens with the host driving
  property p_start; $fell(cs_b) |-> h_io_oe != 4'h0 && d_io_oe == 4'h0; endproperty
  a_start: assert property (p_start) else $error("frame start without host drive");
  // flash starts driving only inside a frame, host released
  property p_drv; $rose(|d_io_oe) |-> !cs_b && h_io_oe == 4'h0; endproperty
  a_drv: assert property (p_drv) else $error("flash drove before host release");

  c_dual: cover property (d_io_oe == 4'h3);
  c_quad: cover property (d_io_oe == 4'hf);
  c_frame: cover property ($fell(cs_b));
endmodule : fre_asserts

// >>> tb/tb_multi_io_fast_read_engine.sv
/*
  bench: host and flash ends joined by the link, host ordered over APB.
  assumes the package, link interface and both ends from src.
*/
`timescale 1ns/10ps
module tb_multi_io_fast_read_engine;
  import fre_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        qe = 1'b0, soft_rst = 1'b0, mem_we = 1'b0;
  logic [7:0]  mem_addr = 8'h00, mem_wdata = 8'h00;
  logic        cont_active, wrap_disable_bit;
  logic [1:0]  wrap_length_field;
  int          err_total = 0, compares = 0;

  // 50 ns system clock
  always #25 clock = ~clock;

  fre_link_if fre_link_if_i ();
  fre_spi_host fre_spi_host_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(fre_link_if_i.host));
  fre_flash_dev fre_flash_dev_i (.clock(clock), .rst_b(rst_b), .link(fre_link_if_i.dev), .quad_io_enable_bit(qe),
    .soft_rst(soft_rst), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .cont_active(cont_active),
    .wrap_disable_bit(wrap_disable_bit), .wrap_length_field(wrap_length_field));
  fre_asserts fre_asserts_i (.clock(clock), .rst_b(rst_b), .cs_b(fre_link_if_i.cs_b), .sclk(fre_link_if_i.sclk),
    .h_io_o(fre_link_if_i.h_io_o), .h_io_oe(fre_link_if_i.h_io_oe), .d_io_o(fre_link_if_i.d_io_o),
    .d_io_oe(fre_link_if_i.d_io_oe));

  // array byte pattern
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a * 8'h07 + 8'h03;
  endfunction : pat

  // four bytes from consecutive addresses, oldest high
  function automatic logic [31:0] lin(input logic [7:0] a);
    return {pat(a), pat(a + 8'h01), pat(a + 8'h02), pat(a + 8'h03)};
  endfunction : lin

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one link command of four bytes, result word back
  task automatic run(input logic [8:0] ctl, input logic [23:0] a, input logic [7:0] md, output logic [31:0] r);
    logic [31:0] s;
    int          n;
    apb(1'b1, REG_ADDR, 32'(a), s);
    apb(1'b1, REG_MODE, 32'(md), s);
    apb(1'b1, REG_COUNT, 32'h0000_0004, s);
    apb(1'b1, REG_CTRL, 32'(ctl), s);
    s = 32'h0000_0001;
    n = 0;
    while (s[0] !== 1'b0 && n < 3000) begin
      apb(1'b0, REG_STAT, 32'h0000_0000, s);
      n++;
    end
    // busy never cleared: the poll limit counts as a mismatch
    if (s[0] !== 1'b0) begin
      err_total++;
      $display("MISMATCH t=%0t busy=%h exp=%h", $time, s, 32'h0000_0000);
    end
    apb(1'b0, REG_RDATA, 32'h0000_0000, r);
  endtask : run

  task automatic t_out;
    logic [31:0] r;
    run(9'(OP_DUAL_OUT), 24'h00_0010, 8'hff, r);
    chk(r, lin(8'h10));
    run(9'(OP_QUAD_OUT), 24'h00_01fe, 8'hff, r);
    chk(r, lin(8'hfe));
    qe <= 1'b0;
    run(9'(OP_QUAD_OUT), 24'h00_0010, 8'hff, r);
    chk(r, 32'hffff_ffff);
    run(9'(OP_QUAD_IO), 24'h00_0010, 8'hff, r);
    chk(r, 32'hffff_ffff);
    qe <= 1'b1;
    $display("test out done");
  endtask : t_out

  // arm continuous read, then use it and leave it
  task automatic t_cont(input logic [7:0] op);
    logic [31:0] r;
    run(9'(op), 24'h00_0040, 8'h2f, r);
    chk(r, lin(8'h40));
    chk(32'(cont_active), 32'h0000_0001);
    run({1'b1, op}, 24'h00_0080, 8'hff, r);
    chk(r, lin(8'h80));
    chk(32'(cont_active), 32'h0000_0000);
    $display("test cont %h done", op);
  endtask : t_cont

  task automatic t_wrap;
    logic [31:0] r;
    logic [7:0]  a;
    for (int len = 0; len < 4; len++) begin
      a = 8'h7e + (8'h08 << len);
      run(9'(OP_SET_WRAP), 24'h00_0000, 8'h8f | 8'(len << 5), r);
      chk(32'({wrap_disable_bit, wrap_length_field}), 32'(len));
      run(9'(OP_QUAD_IO), 24'(a), 8'hff, r);
      chk(r, {pat(a), pat(a + 8'h01), pat(8'h80), pat(8'h81)});
    end
    run(9'(OP_QUAD_OUT), 24'(a), 8'hff, r);
    chk(r, lin(a));
    run(9'(OP_SET_WRAP), 24'h00_0000, 8'h10, r);
    run(9'(OP_QUAD_IO), 24'(a), 8'hff, r);
    chk(r, lin(a));
    run(9'(OP_SET_WRAP), 24'h00_0000, 8'h60, r);
    soft_rst <= 1'b1;
    @(posedge clock);
    soft_rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'(wrap_disable_bit), 32'h0000_0001);
    $display("test wrap done");
  endtask : t_wrap

  task automatic final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk(32'({cont_active, wrap_disable_bit, wrap_length_field}), 32'h0000_0004);
    for (int i = 0; i < 256; i++) begin
      @(posedge clock);
      mem_we <= 1'b1;
      mem_addr <= 8'(i);
      mem_wdata <= pat(8'(i));
    end
    @(posedge clock);
    mem_we <= 1'b0;
    qe <= 1'b1;
    t_out;
    t_cont(OP_DUAL_IO);
    t_cont(OP_QUAD_IO);
    t_wrap;
    final_report;
  end

  // watchdog against a hung link
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    final_report;
  end
endmodule : tb_multi_io_fast_read_engine
